/* File: common/tunnel_pkg.sv */
// shared constants for the spi tunnel target and its host controller
// assumes both ends run on one 20 mhz clock and meet in tunnel_if
package tunnel_pkg;
  // ***************************************************************
  // command codes and select fields
  // ***************************************************************
  localparam logic [7:0] CMD_ATOMIC_READ = 8'h0d;
  localparam logic [7:0] CMD_FIFO_READ = 8'h0b;
  localparam logic [7:0] CMD_FULL_DUPLEX = 8'h09;
  localparam logic [1:0] SEL_PRIMARY = 2'h0;
  localparam logic [1:0] SEL_SERIAL_DATA_PIN_TWO = 2'h1;
  localparam logic [1:0] SEL_ADDR2 = 2'h2;
  localparam logic [1:0] DSRC_ADDR2 = 2'h1;
  localparam logic [1:0] DSRC_SERIAL_DATA_PIN_TWO = 2'h2;
  localparam logic [8:0] AR_MAX_WRITES = 9'h0ff;
  localparam logic [8:0] MAX_BYTES = 9'h100;
  // ***************************************************************
  // pin sampling: sck, mosi, primary, addr2, serial_data_pin_two (selects idle high)
  // ***************************************************************
  localparam int PIN_SCK = 0;
  localparam int PIN_MOSI = 1;
  localparam logic [4:0] SYNC_IDLE = 5'h1c;
  localparam logic [2:0] SEL_IDLE = 3'h7;
  // ***************************************************************
  // host command port
  // ***************************************************************
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_NODE = 5'h04;
  localparam logic [4:0] REG_LEN = 5'h08;
  localparam logic [4:0] REG_COUNT = 5'h0c;
  localparam logic [4:0] REG_TXDATA = 5'h10;
  localparam logic [4:0] REG_RXDATA = 5'h14;
  localparam logic [4:0] REG_STATUS = 5'h18;
  localparam logic [1:0] KIND_ATOMIC_READ = 2'h0;
  localparam logic [1:0] KIND_FIFO_READ = 2'h1;
  localparam logic [1:0] KIND_DUPLEX_CMD = 2'h2;
  localparam logic [1:0] KIND_DUPLEX_REG = 2'h3;
  localparam logic [1:0] HDR_NONE = 2'h0;
  localparam logic [1:0] HDR_FIFO = 2'h1;
  localparam logic [1:0] HDR_LONG = 2'h3;
  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCK_HALF_NS = 500;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
endpackage

/* File: common/tunnel_if.sv */
// spi pins between the tunnel host controller and the tunnel target
// assumes the bench joins the two modports; all pins are one-way
interface tunnel_if;
  logic sck;
  logic mosi;
  logic miso;
  logic primary_select_pin_n;
  logic secondary_address_pin_n;
  logic serial_data_pin_two_n;
  modport target (
    input sck,
    input mosi,
    input primary_select_pin_n,
    input secondary_address_pin_n,
    input serial_data_pin_two_n,
    output miso
  );
  modport host (
    output sck,
    output mosi,
    output primary_select_pin_n,
    output secondary_address_pin_n,
    output serial_data_pin_two_n,
    input miso
  );
endinterface

/* File: core/tunnel_target.sv */
// spi tunnel target: atomic read, fifo read and full duplex framing
// assumes pins come asynchronously and the tunnel side shares CLK
//
// Behaviour
// - atomic read while busy raises bad command
// - incomplete atomic read sets tunnel error flag
// - atomic read: command, node, length, write bytes
// - remote writes N bytes, then reads LEN+1
// - host waits busy clear before fifo read
// - invalid first byte: bad command, rest ignored
// - fifo read returns most recent read data
// - fifo over-read returns zeros, sets underflow
// - fifo read only on primary select
// - fifo read: command, then read bytes out
// - duplex: command, node, length, LEN+1 data bytes
// - register duplex via addr2 or serial_data_pin_two select
// - duplex returns previous duplex read data
// - duplex without duplex predecessor returns zeros
// - early start begins remote before full payload
// - duplex while busy raises bad command
// - host reads fifo between unequal duplex lengths
// - size register sets register duplex length
// - atomic read writes 0 to 255 bytes
// - node byte: select, main flag, sub id
// - busy from first byte until tunnel done
module tunnel_target (
  input wire logic CLK,
  input wire logic NRST,
  tunnel_if.target LINK,
  output logic TUN_VALID,
  output logic [7:0] TUN_DATA,
  output logic TUN_GO,
  output logic TUN_KIND,
  output logic [1:0] TUN_SEL,
  output logic TUN_MAIN,
  output logic [3:0] TUN_SUB_ID,
  output logic [7:0] TUN_LEN,
  output logic [8:0] TUN_WCNT,
  input wire logic RD_VALID,
  input wire logic [7:0] RD_DATA,
  input wire logic TUN_ERR,
  input wire logic [1:0] DUPLEX_SRC,
  input wire logic [7:0] DUPLEX_SIZE,
  input wire logic [7:0] DUPLEX_TARGET,
  input wire logic EARLY_START,
  input wire logic [2:0] FLAG_CLR,
  output logic BUSY,
  output logic BAD_CMD,
  output logic TUN_ERROR,
  output logic FIFO_UNDERFLOW
);
  import tunnel_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CMD = 6'h02,
    ST_NODE = 6'h04,
    ST_LEN = 6'h08,
    ST_DATA = 6'h10,
    ST_FIFO = 6'h20
  } dstate_type;

  // two banks so a duplex can replay old data while new data arrives
  typedef struct packed {
    logic [4:0] s1, s2, s3, f;
    dstate_type st;
    logic skip, frame, kind_fd, ret_prev, prev_fd, busy, sent_all;
    logic bad, terr, unf;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh, tx_sh, node, len;
    logic [8:0] wcnt, rcnt, idx, wout;
    logic bank, tv, go;
    logic [7:0] td;
    logic [1:0][255:0][7:0] mem;
  } dev_type;

  dev_type r, n;
  logic [4:0] fn;
  logic rise, fall, set_bad, set_terr, set_unf;
  logic [7:0] b, nb;
  logic [8:0] wnxt, fi;

  // opens a tunnel transaction and flips the capture bank
  function automatic dev_type start_tx(input dev_type s, input logic fd);
    dev_type t;
    t = s;
    t.busy = 1'b1;
    t.sent_all = 1'b0;
    t.bank = ~s.bank;
    t.rcnt = 9'h000;
    t.wcnt = 9'h000;
    t.kind_fd = fd;
    t.ret_prev = fd & s.prev_fd;
    t.prev_fd = fd;
    return t;
  endfunction

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    n = r;
    set_bad = 1'b0;
    set_terr = 1'b0;
    set_unf = 1'b0;
    b = {r.rx_sh[6:0], 1'b0};
    nb = 8'h00;
    wnxt = r.wcnt + 9'h001;
    fi = 9'h000;
    // a change counts only once stages two and three agree
    fn = (r.s2 & r.s3) | (r.f & (r.s2 ^ r.s3));
    n.s1 = {LINK.serial_data_pin_two_n, LINK.secondary_address_pin_n,
            LINK.primary_select_pin_n, LINK.mosi, LINK.sck};
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.f = fn;
    rise = fn[PIN_SCK] & ~r.f[PIN_SCK];
    fall = ~fn[PIN_SCK] & r.f[PIN_SCK];
    n.tv = 1'b0;
    n.go = 1'b0;
    // read data coming back through the tunnel
    if (RD_VALID && r.rcnt != MAX_BYTES)
    begin
      n.mem[r.bank][r.rcnt[7:0]] = RD_DATA;
      n.rcnt = r.rcnt + 9'h001;
    end
    if (TUN_ERR && r.busy)
    begin
      set_terr = 1'b1;
      n.busy = 1'b0;
    end
    else if (r.busy && r.sent_all && r.rcnt == {1'b0, r.len} + 9'h001)
    begin
      n.busy = 1'b0;
      n.sent_all = 1'b0;
    end
    if (!r.frame && fn[4:2] != SEL_IDLE)
    begin
      n.frame = 1'b1;
      n.bit_cnt = 3'h0;
      n.tx_sh = 8'h00;
      n.skip = 1'b0;
      n.st = ST_CMD;
      if ((DUPLEX_SRC == DSRC_ADDR2 && !fn[3]) ||
          (DUPLEX_SRC == DSRC_SERIAL_DATA_PIN_TWO && !fn[4]))
      begin
        if (r.busy)
        begin
          set_bad = 1'b1;
          n.skip = 1'b1;
        end
        else
        begin
          n = start_tx(n, 1'b1);
          n.node = DUPLEX_TARGET;
          n.len = DUPLEX_SIZE;
          n.st = ST_DATA;
          n.go = EARLY_START;
          n.wout = {1'b0, DUPLEX_SIZE} + 9'h001;
          n.tx_sh = r.prev_fd ? r.mem[r.bank][0] : 8'h00;
        end
      end
      else if (fn[2])
        n.skip = 1'b1;
    end
    else if (r.frame && fn[4:2] == SEL_IDLE)
    begin
      n.frame = 1'b0;
      n.st = ST_IDLE;
      if (r.st == ST_DATA && !r.kind_fd && !r.skip)
      begin
        n.go = 1'b1;
        n.wout = r.wcnt;
        n.sent_all = 1'b1;
      end
      else if (r.busy && !r.sent_all && !r.skip)
      begin
        set_terr = 1'b1;
        n.busy = 1'b0;
      end
    end
    else if (r.frame)
    begin
      // hold the msb across a byte boundary so the new byte survives
      if (fall && r.bit_cnt != 3'h0)
        n.tx_sh = {r.tx_sh[6:0], 1'b0};
      if (rise)
      begin
        b = {r.rx_sh[6:0], fn[PIN_MOSI]};
        n.rx_sh = b;
        n.bit_cnt = r.bit_cnt + 3'h1;
      end
      if (rise && r.bit_cnt == 3'h7 && !r.skip)
      begin
        unique case (r.st)
          ST_CMD:
          begin
            if (b == CMD_FIFO_READ)
            begin
              n.st = ST_FIFO;
              n.idx = 9'h000;
            end
            else if (b == CMD_ATOMIC_READ || b == CMD_FULL_DUPLEX)
            begin
              if (r.busy)
              begin
                set_bad = 1'b1;
                n.skip = 1'b1;
              end
              else
              begin
                n = start_tx(n, b == CMD_FULL_DUPLEX);
                n.st = ST_NODE;
              end
            end
            else
            begin
              set_bad = 1'b1;
              n.skip = 1'b1;
            end
          end
          ST_NODE:
          begin
            n.node = b;
            n.st = ST_LEN;
          end
          ST_LEN:
          begin
            n.len = b;
            n.st = ST_DATA;
            n.wout = {1'b0, b} + 9'h001;
            n.go = r.kind_fd & EARLY_START;
            if (r.ret_prev)
              nb = r.mem[~r.bank][0];
          end
          ST_DATA:
          begin
            // an atomic read forwards at most 255 write bytes
            if (r.kind_fd || r.wcnt != AR_MAX_WRITES)
            begin
              n.td = b;
              n.tv = 1'b1;
              n.wcnt = wnxt;
            end
            if (r.kind_fd && r.wcnt == {1'b0, r.len})
            begin
              n.go = ~EARLY_START;
              n.sent_all = 1'b1;
              n.skip = 1'b1;
            end
            else if (r.ret_prev)
              nb = r.mem[~r.bank][wnxt[7:0]];
          end
          ST_FIFO:
          begin
            nb = 8'h00;
          end
          default:
          begin
            nb = 8'h00;
          end
        endcase
        // fifo read streams the bank filled last
        if (n.st == ST_FIFO)
        begin
          fi = (r.st == ST_FIFO) ? r.idx : 9'h000;
          if (fi < r.rcnt)
            nb = r.mem[r.bank][fi[7:0]];
          else
            set_unf = 1'b1;
          if (fi != MAX_BYTES)
            n.idx = fi + 9'h001;
        end
        n.tx_sh = nb;
      end
    end
    // a set in the same cycle as its clear wins
    n.bad = (r.bad & ~FLAG_CLR[0]) | set_bad;
    n.terr = (r.terr & ~FLAG_CLR[1]) | set_terr;
    n.unf = (r.unf & ~FLAG_CLR[2]) | set_unf;
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.s1 <= SYNC_IDLE;
      r.s2 <= SYNC_IDLE;
      r.s3 <= SYNC_IDLE;
      r.f <= SYNC_IDLE;
    end
    else
      r <= n;
  end

  // outputs straight from flops
  assign LINK.miso = r.tx_sh[7];
  assign TUN_VALID = r.tv;
  assign TUN_DATA = r.td;
  assign TUN_GO = r.go;
  assign TUN_KIND = r.kind_fd;
  assign TUN_SEL = r.node[7:6];
  assign TUN_MAIN = r.node[5];
  assign TUN_SUB_ID = r.node[3:0];
  assign TUN_LEN = r.len;
  assign TUN_WCNT = r.wout;
  assign BUSY = r.busy;
  assign BAD_CMD = r.bad;
  assign TUN_ERROR = r.terr;
  assign FIFO_UNDERFLOW = r.unf;
endmodule // tunnel_target

/* File: core/tunnel_host.sv */
// spi host controller that frames tunnel transactions from registers
// assumes software polls status; the target samples pins on its clock
module tunnel_host #(
  parameter int unsigned SCK_HALF = tunnel_pkg::SCK_HALF_CYC
) (
  input wire logic CLK,
  input wire logic NRST,
  tunnel_if.host LINK,
  input wire logic [4:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA
);
  import tunnel_pkg::*;

  // ***************************************************************
  // state
  // ***************************************************************
  typedef enum logic [2:0] {
    HS_IDLE = 3'h1,
    HS_SHIFT = 3'h2,
    HS_HOLD = 3'h4
  } hstate_type;

  typedef struct packed {
    hstate_type st;
    logic s1, s2, s3, f;
    logic [7:0] div;
    logic sck, mosi;
    logic [2:0] sel;
    logic [2:0] bit_cnt;
    logic [7:0] sh_out, sh_in, node, len;
    logic [9:0] bidx, total;
    logic [1:0] hdr, kind;
    logic alt;
    logic [8:0] wcnt, wptr, rptr, rxcnt;
    logic [31:0] rdata;
    logic [255:0][7:0] tx, rx;
  } host_type;

  host_type r, n;
  logic fn;
  logic [9:0] nxt;

  // byte k of the frame: header bytes first, then payload
  function automatic logic [7:0] pick(input host_type s,
                                      input logic [9:0] k);
    logic [9:0] j;
    j = k - {8'h00, s.hdr};
    if (s.hdr != HDR_NONE && k == 10'h000)
      return (s.kind == KIND_FIFO_READ) ? CMD_FIFO_READ :
             (s.kind == KIND_ATOMIC_READ) ? CMD_ATOMIC_READ :
             CMD_FULL_DUPLEX;
    if (s.kind == KIND_FIFO_READ)
      return 8'h00;
    if (s.hdr == HDR_LONG && k == 10'h001)
      return s.node;
    if (s.hdr == HDR_LONG && k == 10'h002)
      return s.len;
    return s.tx[j[7:0]];
  endfunction

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    n = r;
    nxt = r.bidx + 10'h001;
    fn = (r.s2 & r.s3) | (r.f & (r.s2 ^ r.s3));
    n.s1 = LINK.miso;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.f = fn;
    n.rdata = 32'h0000_0000;
    // command port
    if (WR && ADDR == REG_NODE)
      n.node = WDATA[7:0];
    if (WR && ADDR == REG_LEN)
      n.len = WDATA[7:0];
    if (WR && ADDR == REG_COUNT)
      n.wcnt = WDATA[8:0];
    if (WR && ADDR == REG_TXDATA && r.wptr != MAX_BYTES)
    begin
      n.tx[r.wptr[7:0]] = WDATA[7:0];
      n.wptr = r.wptr + 9'h001;
    end
    if (RD && ADDR == REG_STATUS)
      n.rdata = {22'h000000, r.rxcnt, r.st != HS_IDLE};
    if (RD && ADDR == REG_RXDATA)
    begin
      n.rdata = {24'h000000, r.rx[r.rptr[7:0]]};
      if (r.rptr != MAX_BYTES)
        n.rptr = r.rptr + 9'h001;
    end
    // a start is ignored while a frame runs, the busy wait is software's
    if (WR && ADDR == REG_CTRL && r.st == HS_IDLE)
    begin
      n.kind = WDATA[1:0];
      n.alt = WDATA[2];
      n.hdr = (WDATA[1:0] == KIND_DUPLEX_REG) ? HDR_NONE :
              (WDATA[1:0] == KIND_FIFO_READ) ? HDR_FIFO : HDR_LONG;
      n.total = {8'h00, n.hdr} + {1'b0, r.wcnt};
      if (n.total != 10'h000)
      begin
        n.st = HS_SHIFT;
        // fifo read and commands only on the primary select
        n.sel = (n.kind != KIND_DUPLEX_REG) ? 3'h1 :
                n.alt ? 3'h4 : 3'h2;
        n.div = 8'h00;
        n.sck = 1'b0;
        n.bit_cnt = 3'h0;
        n.bidx = 10'h000;
        n.rptr = 9'h000;
        n.rxcnt = 9'h000;
        n.sh_out = pick(n, 10'h000);
        n.mosi = n.sh_out[7];
      end
    end
    unique case (r.st)
      HS_SHIFT:
      begin
        n.div = r.div + 8'h01;
        if (r.div == 8'(SCK_HALF - 1))
        begin
          n.div = 8'h00;
          n.sck = ~r.sck;
          if (!r.sck)
          begin
            n.sh_in = {r.sh_in[6:0], fn};
            n.bit_cnt = r.bit_cnt + 3'h1;
          end
          else if (r.bit_cnt == 3'h0)
          begin
            // header bytes carry only zeros back
            if (r.bidx >= {8'h00, r.hdr})
            begin
              n.rx[r.rxcnt[7:0]] = r.sh_in;
              n.rxcnt = r.rxcnt + 9'h001;
            end
            if (nxt == r.total)
              n.st = HS_HOLD;
            else
            begin
              n.bidx = nxt;
              n.sh_out = pick(r, nxt);
              n.mosi = n.sh_out[7];
            end
          end
          else
          begin
            n.sh_out = {r.sh_out[6:0], 1'b0};
            n.mosi = r.sh_out[6];
          end
        end
      end
      HS_HOLD:
      begin
        n.div = r.div + 8'h01;
        if (r.div == 8'(SCK_HALF - 1))
        begin
          n.sel = 3'h0;
          n.st = HS_IDLE;
          n.wptr = 9'h000;
        end
      end
      HS_IDLE:
      begin
        n.div = 8'h00;
      end
    endcase
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      r <= '0;
      r.st <= HS_IDLE;
    end
    else
      r <= n;
  end

  assign LINK.sck = r.sck;
  assign LINK.mosi = r.mosi;
  assign LINK.primary_select_pin_n = ~r.sel[0];
  assign LINK.secondary_address_pin_n = ~r.sel[1];
  assign LINK.serial_data_pin_two_n = ~r.sel[2];
  assign RDATA = r.rdata;
endmodule // tunnel_host

/* File: verification/spi_tunnel_checker.sv */
// wire checks for the spi link between tunnel host and tunnel target
// assumes the host runs with an sck half period of 8 clocks
module spi_tunnel_checker (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic primary_select_pin_n,
  input wire logic secondary_address_pin_n,
  input wire logic serial_data_pin_two_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ***************************************************************
  // helper: sck rises counted inside a frame
  // ***************************************************************
  logic [2:0] sel_n;
  logic sck_d_ff;
  logic [11:0] bits_ff;
  assign sel_n = {serial_data_pin_two_n, secondary_address_pin_n,
                  primary_select_pin_n};
  // count restarts whenever every select idles high
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      sck_d_ff <= 1'h0;
      bits_ff <= 12'h000;
    end
    else
    begin
      sck_d_ff <= sck;
      if (&sel_n)
        bits_ff <= 12'h000;
      else if (sck && !sck_d_ff)
        bits_ff <= bits_ff + 12'h001;
    end
  end
  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  reset_idle_a: assert property ($rose(NRST) |-> (&sel_n) && !sck)
    else $error("link not idle after reset");
  sck_idle_a: assert property ((&sel_n) |-> !sck)
    else $error("sck moves outside a frame");
  sel_boundary_a: assert property (
    !(&sel_n) ##1 (&sel_n) |-> bits_ff[2:0] == 3'h0)
    else $error("select released inside a byte");
  sel_edge_a: assert property (
    !$stable(sel_n) |-> !sck && !$past(sck))
    else $error("select changed while sck high");
  mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("mosi changed while sck high");
  one_select_a: assert property ($onehot0(~sel_n))
    else $error("two selects low at once");
  sck_high_a: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
    else $error("sck high phase has wrong length");
  hdr_zero_a: assert property (
    $rose(sck) && !primary_select_pin_n && bits_ff < 12'h008 |-> !miso)
    else $error("miso not zero in first byte");
endmodule // spi_tunnel_checker

/* File: verification/spi_tunnel_read_full_duplex_tb.sv */
// bench: tunnel host and target joined over tunnel_if, model compare
// assumes a behavioural remote peripheral on the target tunnel ports
module spi_tunnel_read_full_duplex_tb;
  import tunnel_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = 1'h0, NRST = 1'h0, WR = 1'h0, RD = 1'h0;
  logic [4:0] ADDR = 5'h00;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic TUN_VALID, TUN_GO, TUN_KIND, TUN_MAIN, BUSY, BAD_CMD;
  logic TUN_ERROR, FIFO_UNDERFLOW;
  logic [7:0] TUN_DATA, TUN_LEN;
  logic [1:0] TUN_SEL;
  logic [3:0] TUN_SUB_ID;
  logic [8:0] TUN_WCNT;
  logic RD_VALID = 1'h0, TUN_ERR = 1'h0, EARLY_START = 1'h0;
  logic [7:0] RD_DATA = 8'h0, DUPLEX_SIZE = 8'h0, DUPLEX_TARGET = 8'h0;
  logic [1:0] DUPLEX_SRC = 2'h0;
  logic [2:0] FLAG_CLR = 3'h0;
  integer seed = 32'hedebb9a7;
  int fails = 0, n_compared = 0, pend = 0, gwc, L, i;
  bit stall = 0, dup = 0;
  logic [7:0] tx[$], rx[$], wq[$], rq[$], bank[$], ex[$];
  logic [7:0] node, rd_b;
  always #25 CLK = ~CLK;
  // ***************************************************************
  // design ends, link and wire checker
  // ***************************************************************
  tunnel_if link ();
  tunnel_host #(.SCK_HALF(8)) tunnel_host_i (.CLK, .NRST,
    .LINK(link.host), .ADDR, .WDATA, .WR, .RD, .RDATA);
  tunnel_target tunnel_target_i (.CLK, .NRST, .LINK(link.target),
    .TUN_VALID, .TUN_DATA, .TUN_GO, .TUN_KIND, .TUN_SEL, .TUN_MAIN,
    .TUN_SUB_ID, .TUN_LEN, .TUN_WCNT, .RD_VALID, .RD_DATA, .TUN_ERR,
    .DUPLEX_SRC, .DUPLEX_SIZE, .DUPLEX_TARGET, .EARLY_START, .FLAG_CLR,
    .BUSY, .BAD_CMD, .TUN_ERROR, .FIFO_UNDERFLOW);
  spi_tunnel_checker checker_i (.CLK, .NRST, .sck(link.sck),
    .mosi(link.mosi), .miso(link.miso),
    .primary_select_pin_n(link.primary_select_pin_n),
    .secondary_address_pin_n(link.secondary_address_pin_n),
    .serial_data_pin_two_n(link.serial_data_pin_two_n));
  // remote peripheral: answers every other cycle so replies trickle in
  always @(posedge CLK)
  begin
    if (TUN_VALID === 1'h1)
      wq.push_back(TUN_DATA);
    RD_VALID <= 1'h0;
    if (TUN_GO === 1'h1 && !stall)
    begin
      gwc = wq.size();
      pend = TUN_LEN + 1;
    end
    else if (pend > 0 && RD_VALID !== 1'h1)
    begin
      rd_b = 8'($random(seed));
      RD_DATA <= rd_b;
      RD_VALID <= 1'h1;
      rq.push_back(rd_b);
      pend--;
    end
  end
  // ***************************************************************
  // tasks
  // ***************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task cmpq(input logic [7:0] a[$], input logic [7:0] b[$]);
    chk(a.size(), b.size());
    foreach (b[k]) chk(a[k], b[k]);
  endtask
  task tally_and_finish;
    $display("compared %0d, mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'h1;
    @(posedge CLK);
    WR <= 1'h0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'h1;
    @(posedge CLK);
    RD <= 1'h0;
    #1;
    d = RDATA;
  endtask
  task fill(input int n);
    tx.delete();
    repeat (n) tx.push_back(8'($random(seed)));
  endtask
  task zq(input int n);
    ex.delete();
    repeat (n) ex.push_back(8'h00);
  endtask
  // frame from registers, wait running and optionally busy, pop rx
  task frame(input logic [1:0] kind, input logic [7:0] lm1,
             input int cnt, input bit wb);
    logic [31:0] d;
    wq.delete();
    rx.delete();
    rq.delete();
    foreach (tx[k]) wr(REG_TXDATA, {24'h0, tx[k]});
    wr(REG_NODE, {24'h0, node});
    wr(REG_LEN, {24'h0, lm1});
    wr(REG_COUNT, cnt);
    wr(REG_CTRL, {30'h0, kind});
    repeat (4) @(posedge CLK);
    d = 32'h1;
    for (int k = 0; k < 9000 && d[0] !== 1'h0; k++) rd(REG_STATUS, d);
    for (int k = 0; k < 9000 && wb && BUSY !== 1'h0; k++) @(posedge CLK);
    if (d[0] !== 1'h0 || (wb && BUSY !== 1'h0))
    begin
      fails++;
      $display("[FAIL] %0t wait ran out", $time);
      tally_and_finish();
    end
    repeat (cnt)
    begin
      rd(REG_RXDATA, d);
      rx.push_back(d[7:0]);
    end
  endtask
  task clr;
    @(posedge CLK);
    FLAG_CLR <= 3'h7;
    @(posedge CLK);
    FLAG_CLR <= 3'h0;
    @(posedge CLK);
    #1;
    chk({BAD_CMD, TUN_ERROR, FIFO_UNDERFLOW}, 3'h0);
  endtask
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial
  begin
    repeat (5) @(posedge CLK);
    NRST <= 1'h1;
    repeat (4) @(posedge CLK);
    // two command duplexes: zeros first, then the earlier replies
    L = 2 + ($random(seed) & 3);
    for (i = 0; i < 2; i++)
    begin
      node = {2'(i), 1'h1, 1'h0, 4'($random(seed))};
      fill(L);
      frame(KIND_DUPLEX_CMD, 8'(L - 1), L, 1);
      if (dup)
        ex = bank;
      else
        zq(L);
      cmpq(rx, ex);
      cmpq(wq, tx);
      chk(gwc, L);
      chk({TUN_KIND, TUN_SEL, TUN_MAIN, TUN_SUB_ID}, {1'h1, node[7:5], node[3:0]});
      chk(TUN_LEN, L - 1);
      bank = rq;
      dup = 1;
    end
    $display("duplex test done");
    // fifo read one byte beyond what was fetched
    tx.delete();
    frame(KIND_FIFO_READ, 8'h00, L + 1, 0);
    ex = bank;
    ex.push_back(8'h00);
    cmpq(rx, ex);
    chk(FIFO_UNDERFLOW, 1'h1);
    clr();
    $display("fifo underflow test done");
    // register duplex on the secondary pin, size from the port
    @(posedge CLK);
    DUPLEX_SRC <= DSRC_ADDR2;
    DUPLEX_SIZE <= 8'(L - 1);
    DUPLEX_TARGET <= {SEL_ADDR2, 6'h05};
    fill(L);
    frame(KIND_DUPLEX_REG, 8'h00, L, 1);
    cmpq(rx, bank);
    cmpq(wq, tx);
    chk(TUN_SEL, SEL_ADDR2);
    @(posedge CLK);
    DUPLEX_SRC <= 2'h0;
    $display("register duplex test done");
    // atomic read: zeros back, writes forwarded, reply via fifo read
    node = {SEL_SERIAL_DATA_PIN_TWO, 6'h03};
    fill(1 + ($random(seed) & 3));
    frame(KIND_ATOMIC_READ, 8'(L - 1), tx.size(), 1);
    zq(tx.size());
    cmpq(rx, ex);
    cmpq(wq, tx);
    chk({TUN_KIND, TUN_WCNT}, {1'h0, 9'(tx.size())});
    chk(rq.size(), L);
    bank = rq;
    tx.delete();
    frame(KIND_FIFO_READ, 8'h00, L, 0);
    cmpq(rx, bank);
    $display("atomic read test done");
    // duplex after an atomic read starts from zeros; early start on
    @(posedge CLK);
    EARLY_START <= 1'h1;
    node = 8'h21;
    fill(L);
    frame(KIND_DUPLEX_CMD, 8'(L - 1), L, 1);
    zq(L);
    cmpq(rx, ex);
    chk(gwc < L, 1'h1);
    @(posedge CLK);
    EARLY_START <= 1'h0;
    $display("early start test done");
    // stalled remote keeps busy; a second request is refused
    stall = 1;
    fill(1);
    frame(KIND_ATOMIC_READ, 8'h00, 1, 0);
    chk(BUSY, 1'h1);
    frame(KIND_ATOMIC_READ, 8'h00, 1, 0);
    chk(BAD_CMD, 1'h1);
    clr();
    // a duplex while the stalled read still holds busy is refused too
    frame(KIND_DUPLEX_CMD, 8'h00, 1, 0);
    chk(BAD_CMD, 1'h1);
    @(posedge CLK);
    TUN_ERR <= 1'h1;
    @(posedge CLK);
    TUN_ERR <= 1'h0;
    repeat (2) @(posedge CLK);
    #1;
    chk({TUN_ERROR, BUSY}, 2'h2);
    stall = 0;
    clr();
    $display("busy refusal test done");
    tally_and_finish();
  end
endmodule // spi_tunnel_read_full_duplex_tb
